// [hw/rfm_fault_monitor.sv]
/*
 * Resolver fault monitor: gathers amplitude, broken-wire, loop-unlock and
 * over-temperature faults, drives live and latched fault pins and a
 * prioritised 3-bit fault code, with an APB register port.
 * Assumes all inputs synchronous to REF_CLK; analog detectors lie outside.
 */
// Summary of operation
// - Compare averaged loop counter against excitation counter in frequency and phase.
// - Flag loop unlock when frequency or phase relation breaks down.
// - No unlock fault while frequency matches and phase relation holds.
// - Loop and excitation counter values are not brought out to pins.
// - Flag over-temperature when junction temperature exceeds 150 degrees.
// - Any fault raises live and latched outputs with its matching code.
// - Amplitude fault gives code 001, priority 3.
// - Broken cosine line gives code 010, priority 1, highest.
// - Broken sine line gives code 011, priority 2.
// - Loop unlock gives code 100, priority 4.
// - Over-temperature code 110, priority 5; 101 unused; 000 means no fault.
// - After reset release present code 111 to mask start-up reporting.
// - With simultaneous faults show only the highest-priority code.
// - Smaller priority number means higher priority.
// - Clear strobe low clears latched output and stored code.
// - Latched output stays high after clear while the cause persists.
// - High level on live or latched output means an error.
// - Fault detection never blocks or alters angle conversion outputs.
`timescale 1ns/1ns
module rfm_fault_monitor
	import rfm_pkg::*;
#(
	parameter int CNT_W = 12,
	parameter logic [CNT_W-1:0] PHASE_OFS = '0,
	parameter logic [CNT_W-1:0] UNLOCK_TOL = 12'h010,
	parameter int MASK_CYC = MASK_CYC_DEF
) (
	input wire logic REF_CLK, // System clock, 100 MHz
	input wire logic RST_B, // Synchronous reset, active low
	input wire logic AMP_FAULT, // Square-sum amplitude below threshold
	input wire logic COS_BROKEN, // Cosine line broken-wire detect
	input wire logic SIN_BROKEN, // Sine line broken-wire detect
	input wire logic [CNT_W-1:0] LOOP_P_CNT, // Counter of first tracking loop
	input wire logic [CNT_W-1:0] LOOP_M_CNT, // Counter of second tracking loop
	input wire logic [CNT_W-1:0] EXC_CNT, // Excitation generating counter
	input wire logic [TEMP_W-1:0] JUNCTION_TEMP, // Temperature indicator, deg C
	input wire logic FAULT_CLEAR_STROBE_N, // Error reset strobe, active low
	output logic LIVE_FAULT_OUT, // Current fault, high on error
	output logic LATCHED_FAULT_OUT, // Held fault, high on error
	output logic FAULT_CODE_BIT0, // Fault code bit 0
	output logic FAULT_CODE_BIT1, // Fault code bit 1
	output logic FAULT_CODE_BIT2, // Fault code bit 2
	input wire logic PSEL, // APB select
	input wire logic PENABLE, // APB enable
	input wire logic PWRITE, // APB direction
	input wire logic [APB_AW-1:0] PADDR, // APB byte address
	input wire logic [31:0] PWDATA, // APB write data
	output logic [31:0] PRDATA, // APB read data
	output logic PREADY, // APB ready
	output logic PSLVERR // APB error
);

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	function automatic logic [2:0] code_rank(input logic [2:0] code);
		case (code)
			CODE_COS: code_rank = RANK_COS;
			CODE_SIN: code_rank = RANK_SIN;
			CODE_AMP: code_rank = RANK_AMP;
			CODE_UNLOCK: code_rank = RANK_UNLOCK;
			CODE_TEMP: code_rank = RANK_TEMP;
			default: code_rank = RANK_NONE;
		endcase
	endfunction

	// Lower rank wins; ties keep the first argument
	function automatic logic [2:0] better(input logic [2:0] a, input logic [2:0] b);
		better = (code_rank(b) < code_rank(a)) ? b : a;
	endfunction

	function automatic logic [2:0] encode(input rfm_src_s s);
		logic [2:0] c;
		c = CODE_NONE;
		if (s.temp) c = better(c, CODE_TEMP);
		if (s.unlock) c = better(c, CODE_UNLOCK);
		if (s.amp) c = better(c, CODE_AMP);
		if (s.sin_brk) c = better(c, CODE_SIN);
		if (s.cos_brk) c = better(c, CODE_COS);
		encode = c;
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	localparam rfm_state_s STATE_RST = '{mode: RFM_MASK, mask_cnt: '0, enable: ENABLE_RST,
		src: '0, clr_n: 1'b1, live: 1'b0, latched: 1'b0, stored: CODE_NONE, rdata: '0};
	localparam logic [MASK_CNT_W-1:0] MASK_LAST = MASK_CNT_W'(MASK_CYC - 1);

	rfm_state_s s_q;
	rfm_state_s s_d;
	logic [CNT_W:0] loop_sum;
	logic [CNT_W-1:0] loop_avg;
	logic [CNT_W-1:0] phase_err;
	logic [CNT_W-1:0] phase_mag;
	logic unlock_raw;
	logic [2:0] cur_code;
	logic clr_now;
	logic apb_wr;
	logic apb_hit;
	logic [31:0] status_word;

	// ----------------------------------------------------------------
	// Loop lock comparison
	// ----------------------------------------------------------------
	// A frequency mismatch shows up as a drifting phase error, so one
	// window on the error covers both; counter values stay internal.
	always_comb begin
		loop_sum = {1'b0, LOOP_P_CNT} + {1'b0, LOOP_M_CNT};
		loop_avg = loop_sum[CNT_W:1];
		phase_err = loop_avg - EXC_CNT - PHASE_OFS;
		phase_mag = phase_err[CNT_W-1] ? CNT_W'(-phase_err) : phase_err;
		unlock_raw = (phase_mag > UNLOCK_TOL);
	end

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	always_comb begin
		// Code of the enabled sources, worked out here so the next-state logic only reads it
		cur_code = encode(rfm_src_s'(s_q.src & s_q.enable));
		apb_hit = (PADDR == OFS_ENABLE) || (PADDR == OFS_STATUS) || (PADDR == OFS_CLEAR);
		apb_wr = PSEL && PENABLE && PWRITE && apb_hit;
		status_word = '0;
		status_word[ST_LIVE] = s_q.live;
		status_word[ST_LATCH] = s_q.latched;
		status_word[ST_CODE_LSB +: 3] = cur_code;
		status_word[ST_STORED_LSB +: 3] = s_q.stored;
		status_word[ST_SRC_LSB +: NSRC] = s_q.src;
		status_word[ST_MASKING] = (s_q.mode == RFM_MASK);
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		// Strobe low, or a software clear write, clears the hold
		clr_now = !s_q.clr_n || (apb_wr && PADDR == OFS_CLEAR && PWDATA[CLR_BIT]);
		s_d.clr_n = FAULT_CLEAR_STROBE_N;
		s_d.src.amp = AMP_FAULT;
		s_d.src.cos_brk = COS_BROKEN;
		s_d.src.sin_brk = SIN_BROKEN;
		s_d.src.unlock = unlock_raw;
		s_d.src.temp = (JUNCTION_TEMP > TEMP_LIMIT_C);
		if (apb_wr && PADDR == OFS_ENABLE) begin
			s_d.enable = PWDATA[NSRC-1:0];
		end
		if (PSEL && !PENABLE) begin
			s_d.rdata = (PADDR == OFS_ENABLE) ? 32'(s_q.enable) :
				(PADDR == OFS_STATUS) ? status_word : '0;
		end
		case (s_q.mode)
			RFM_MASK: begin
				// Reporting stays off until the detectors settle
				s_d.live = 1'b0;
				s_d.latched = 1'b0;
				s_d.stored = CODE_NONE;
				s_d.mask_cnt = s_q.mask_cnt + MASK_CNT_W'(1);
				if (s_q.mask_cnt == MASK_LAST) begin
					s_d.mode = RFM_RUN;
				end
			end
			RFM_RUN: begin
				s_d.live = (cur_code != CODE_NONE);
				// A fault present in the clear cycle wins over the clear
				s_d.latched = (s_q.latched && !clr_now) || (cur_code != CODE_NONE);
				s_d.stored = clr_now ? cur_code : better(s_q.stored, cur_code);
			end
			default: s_d = STATE_RST;
		endcase
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_B) begin
			s_q <= STATE_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Nothing here feeds the angle path, so a fault cannot disturb it
	logic [2:0] code_out;
	always_comb begin
		code_out = (s_q.mode == RFM_MASK) ? CODE_MASK : s_q.stored;
		LIVE_FAULT_OUT = s_q.live;
		LATCHED_FAULT_OUT = s_q.latched;
		FAULT_CODE_BIT0 = code_out[0];
		FAULT_CODE_BIT1 = code_out[1];
		FAULT_CODE_BIT2 = code_out[2];
		PRDATA = s_q.rdata;
		PREADY = 1'b1;
		PSLVERR = PSEL && PENABLE && !apb_hit;
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RST_B);

	logic run_q;
	assign run_q = (s_q.mode == RFM_RUN);

	sequence seq_clear_idle;
		run_q && clr_now && cur_code == CODE_NONE;
	endsequence

	sequence seq_mask_done;
		s_q.mode == RFM_MASK && s_q.mask_cnt == MASK_LAST;
	endsequence

	AST_MASK_CODE: assert property (s_q.mode == RFM_MASK |-> code_out == CODE_MASK && !LATCHED_FAULT_OUT)
		else $error("start-up mask code not shown");
	AST_MASK_END: assert property (seq_mask_done |=> run_q)
		else $error("mask period did not end");
	AST_LIVE_FOLLOW: assert property (run_q && cur_code != CODE_NONE |=> LIVE_FAULT_OUT && LATCHED_FAULT_OUT)
		else $error("fault did not raise both outputs");
	AST_LIVE_DROP: assert property (run_q && cur_code == CODE_NONE |=> !LIVE_FAULT_OUT)
		else $error("live output did not follow fault removal");
	AST_LATCH_HOLD: assert property (LATCHED_FAULT_OUT && !clr_now |=> LATCHED_FAULT_OUT)
		else $error("latched output dropped without clear");
	AST_CLEAR_DROPS: assert property (seq_clear_idle |=> !LATCHED_FAULT_OUT && code_out == CODE_NONE)
		else $error("clear did not empty latch and code");
	AST_CLEAR_KEEPS: assert property (run_q && clr_now && cur_code != CODE_NONE |=> LATCHED_FAULT_OUT)
		else $error("latch released while cause present");
	AST_COS_WINS: assert property (run_q && s_q.src.cos_brk && s_q.enable[1] |=> code_out == CODE_COS)
		else $error("cosine fault not shown first");
	AST_TEMP_CODE: assert property (run_q && (clr_now || s_q.stored == CODE_NONE) && s_q.src == 5'h10 && s_q.enable[4] |=> code_out == CODE_TEMP)
		else $error("temperature code wrong");
	AST_UNLOCK_SEEN: assert property (unlock_raw |=> s_q.src.unlock ##1 (!$past(run_q) || !$past(s_q.enable[3]) || LIVE_FAULT_OUT))
		else $error("unlock not reported");
	AST_LOCK_QUIET: assert property (!unlock_raw |=> !s_q.src.unlock)
		else $error("unlock flagged while locked");
	AST_HOT_SEEN: assert property (JUNCTION_TEMP > TEMP_LIMIT_C |=> s_q.src.temp)
		else $error("over-temperature not flagged");

endmodule // rfm_fault_monitor

// [hw/rfm_pkg.sv]
/*
 * Constants, codes, register map and state types of the resolver fault monitor.
 * Assumes a single 100 MHz clock and a zero-wait APB slave port.
 */
package rfm_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int MASK_TIME_US = 100;
	localparam int MASK_CYC_DEF = MASK_TIME_US * CLK_MHZ;
	localparam int MASK_CNT_W = 16;

	// ----------------------------------------------------------------
	// Fault codes and priority ranks (smaller rank wins)
	// ----------------------------------------------------------------
	localparam logic [2:0] CODE_NONE = 3'h0;
	localparam logic [2:0] CODE_AMP = 3'h1;
	localparam logic [2:0] CODE_COS = 3'h2;
	localparam logic [2:0] CODE_SIN = 3'h3;
	localparam logic [2:0] CODE_UNLOCK = 3'h4;
	localparam logic [2:0] CODE_TEMP = 3'h6;
	localparam logic [2:0] CODE_MASK = 3'h7;
	localparam logic [2:0] RANK_COS = 3'h1;
	localparam logic [2:0] RANK_SIN = 3'h2;
	localparam logic [2:0] RANK_AMP = 3'h3;
	localparam logic [2:0] RANK_UNLOCK = 3'h4;
	localparam logic [2:0] RANK_TEMP = 3'h5;
	localparam logic [2:0] RANK_NONE = 3'h7;

	// ----------------------------------------------------------------
	// Detection thresholds
	// ----------------------------------------------------------------
	localparam int TEMP_W = 9;
	localparam logic [TEMP_W-1:0] TEMP_LIMIT_C = 9'h096;

	// ----------------------------------------------------------------
	// Register map (byte addresses) and fields
	// ----------------------------------------------------------------
	localparam int APB_AW = 8;
	localparam logic [APB_AW-1:0] OFS_ENABLE = 8'h00;
	localparam logic [APB_AW-1:0] OFS_STATUS = 8'h04;
	localparam logic [APB_AW-1:0] OFS_CLEAR = 8'h08;
	localparam int NSRC = 5;
	localparam logic [NSRC-1:0] ENABLE_RST = 5'h1F;
	localparam int ST_LIVE = 0;
	localparam int ST_LATCH = 1;
	localparam int ST_CODE_LSB = 2;
	localparam int ST_STORED_LSB = 5;
	localparam int ST_SRC_LSB = 8;
	localparam int ST_MASKING = 13;
	localparam int CLR_BIT = 0;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		RFM_MASK = 2'b01,
		RFM_RUN = 2'b10
	} rfm_mode_e;

	// Bit order matches the enable register: amp is bit 0
	typedef struct packed {
		logic temp;
		logic unlock;
		logic sin_brk;
		logic cos_brk;
		logic amp;
	} rfm_src_s;

	typedef struct packed {
		rfm_mode_e mode;
		logic [MASK_CNT_W-1:0] mask_cnt;
		logic [NSRC-1:0] enable;
		rfm_src_s src;
		logic clr_n;
		logic live;
		logic latched;
		logic [2:0] stored;
		logic [31:0] rdata;
	} rfm_state_s;

endpackage

// [sim/rfm_fault_monitor_tb_top.sv]
/*
 * Self-checking bench of the resolver fault monitor: codes, priority, clear, APB.
 * Assumes the monitor is built with a short start-up mask of 20 cycles.
 */
`timescale 1ns/1ns
module rfm_fault_monitor_tb_top
	import rfm_pkg::*;
;
	logic ref_clk, rst_b, amp, cos_b, sin_b, clr_req, live, latched, b0, b1, b2;
	logic psel, penable, pwrite, pready, pslverr;
	logic [11:0] p_cnt, m_cnt, e_cnt;
	logic [8:0] temp;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic err;
	wire strobe_n;
	int n_mismatch = 0;
	int samples_checked = 0;
	int cycles = 0;

	rfm_fault_monitor #(.MASK_CYC(20)) u_dut (.REF_CLK(ref_clk), .RST_B(rst_b), .AMP_FAULT(amp),
		.COS_BROKEN(cos_b), .SIN_BROKEN(sin_b), .LOOP_P_CNT(p_cnt), .LOOP_M_CNT(m_cnt), .EXC_CNT(e_cnt),
		.JUNCTION_TEMP(temp), .FAULT_CLEAR_STROBE_N(strobe_n), .LIVE_FAULT_OUT(live),
		.LATCHED_FAULT_OUT(latched), .FAULT_CODE_BIT0(b0), .FAULT_CODE_BIT1(b1), .FAULT_CODE_BIT2(b2),
		.PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
	rfm_host_model u_host (.clk(ref_clk), .clr_req(clr_req), .strobe_n(strobe_n));

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	// Hang guard, well above the few hundred cycles the run needs
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 5000) begin
			n_mismatch++;
			wrap_up();
		end
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	// Bit order amp, cos, sin, unlock, temp
	task automatic drive(input logic [4:0] f);
		amp <= f[0];
		cos_b <= f[1];
		sin_b <= f[2];
		p_cnt <= f[3] ? 12'h300 : 12'h110;
		m_cnt <= f[3] ? 12'h300 : 12'h110;
		temp <= f[4] ? 9'h097 : 9'h096;
		tick(3);
	endtask

	// Looks in mid-cycle, after the last edge's results have settled, then realigns to a rising edge
	task automatic pins(input logic [2:0] code, input logic lv, input logic lt);
		@(negedge ref_clk);
		check("code", {29'h0, b2, b1, b0}, {29'h0, code});
		check("live", {31'h0, live}, {31'h0, lv});
		check("latched", {31'h0, latched}, {31'h0, lt});
		@(posedge ref_clk);
	endtask

	task automatic clear_pin;
		clr_req <= 1'b1;
		tick(1);
		clr_req <= 1'b0;
		tick(4);
	endtask

	// Bus master: holds the request until pready is seen high at an edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		tick(1);
		penable <= 1'b1;
		// The monitor ties pready high, so this wait ends at the first edge
		do begin
			tick(1);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		tick(1);
	endtask

	task automatic t_startup;
		tick(4);
		rst_b <= 1'b1;
		tick(2);
		pins(3'h7, 1'b0, 1'b0);
		tick(25);
		clear_pin();
		pins(3'h0, 1'b0, 1'b0);
	endtask

	task automatic t_codes;
		logic [4:0] f [5] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10};
		logic [2:0] c [5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h6};
		for (int i = 0; i < 5; i++) begin
			drive(f[i]);
			pins(c[i], 1'b1, 1'b1);
			drive(5'h00);
			pins(c[i], 1'b0, 1'b1);
			clear_pin();
			pins(3'h0, 1'b0, 1'b0);
		end
	endtask

	task automatic t_prio;
		drive(5'h10);
		drive(5'h11);
		pins(3'h1, 1'b1, 1'b1);
		drive(5'h1F);
		pins(3'h2, 1'b1, 1'b1);
		drive(5'h1D);
		clear_pin();
		pins(3'h3, 1'b1, 1'b1);
		drive(5'h00);
		clear_pin();
		pins(3'h0, 1'b0, 1'b0);
	endtask

	task automatic t_apb;
		apb(1'b0, OFS_ENABLE, 32'h0);
		check("enable reset", rd, 32'h0000001F);
		apb(1'b1, OFS_ENABLE, 32'h0000001E);
		drive(5'h01);
		pins(3'h0, 1'b0, 1'b0);
		apb(1'b0, OFS_STATUS, 32'h0);
		check("raw sources", {27'h0, rd[12:8]}, 32'h00000001);
		apb(1'b1, OFS_ENABLE, 32'h0000001F);
		tick(3);
		pins(3'h1, 1'b1, 1'b1);
		drive(5'h00);
		apb(1'b1, OFS_CLEAR, 32'h00000001);
		tick(3);
		pins(3'h0, 1'b0, 1'b0);
		apb(1'b0, 8'h0C, 32'h0);
		check("unmapped err", {31'h0, err}, 32'h00000001);
		check("unmapped data", rd, 32'h0);
	endtask

	// Mid-run reset drops a held fault and brings the start-up mask back
	task automatic t_reset;
		drive(5'h02);
		pins(3'h2, 1'b1, 1'b1);
		rst_b <= 1'b0;
		tick(2);
		rst_b <= 1'b1;
		tick(2);
		pins(3'h7, 1'b0, 1'b0);
		drive(5'h00);
		tick(25);
		pins(3'h0, 1'b0, 1'b0);
	endtask

	initial begin
		rst_b = 1'b0;
		amp = 1'b0;
		cos_b = 1'b0;
		sin_b = 1'b0;
		clr_req = 1'b0;
		p_cnt = 12'h110;
		m_cnt = 12'h110;
		e_cnt = 12'h100;
		temp = 9'h096;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		t_startup();
		t_codes();
		t_prio();
		t_apb();
		t_reset();
		wrap_up();
	end
endmodule // rfm_fault_monitor_tb_top

// [sim/rfm_host_model.sv]
/*
 * Host controller model that clears the held fault through the active-low strobe.
 * Assumes the bench raises clr_req for one cycle, right after a rising edge.
 */
`timescale 1ns/1ns
module rfm_host_model
	import rfm_pkg::*;
(
	input wire logic clk, // Device clock
	input wire logic clr_req, // Clear request from the bench
	output logic strobe_n // Clear strobe, active low
);
	// One low cycle only, the shortest clear the device must accept
	initial begin
		strobe_n = 1'b1;
		forever @(posedge clk) strobe_n <= !clr_req;
	end
endmodule // rfm_host_model
